// ### pkg/cmc_consts.svh
// Constants for the CAN operating-mode controller: mode codes, field positions, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH

`define CMC_MODE_NORMAL   3'h0
`define CMC_MODE_DISABLE  3'h1
`define CMC_MODE_LOOP     3'h2
`define CMC_MODE_LISTEN   3'h3
`define CMC_MODE_CONFIG   3'h4
`define CMC_CFG_BIT       2
`define CMC_MODE_RESET    3'h4

`define CMC_RXM_ACCEPT_ALL 2'h3

`define CMC_IDLE_BITS     4'hB

`define CMC_CLK_MHZ       250
`define CMC_FILT_NS       50
`define CMC_FILT_CYC      ((`CMC_FILT_NS * `CMC_CLK_MHZ + 999) / 1000)

`define CMC_PSM_W         8
`define CMC_BITCNT_W      8

`endif

// ### pkg/cmc_pkg.sv
// Types shared by the mode controller and its bus-activity detector.
// Assumes the constants header is on the include path.
`include "cmc_consts.svh"

package cmc_pkg;

	typedef logic [2:0] cmc_mode_t;

	typedef enum logic [1:0] {
		ST_SETTLED,
		ST_PENDING,
		ST_REJOIN,
		ST_WAKE_RX
	} cmc_state_t;

endpackage : cmc_pkg

// ### pkg/cmc_det_if.sv
// Carrier between the mode controller and the bus-activity detector.
// Assumes both ends run on the system clock.
interface cmc_det_if;

	logic ce;
	logic loop_on;
	logic loop_tx;
	logic filt_on;
	logic rx_int;
	logic bus_idle;
	logic wake_evt;

	modport det (
		input  ce,
		input  loop_on,
		input  loop_tx,
		input  filt_on,
		output rx_int,
		output bus_idle,
		output wake_evt
	);

	modport ctl (
		output ce,
		output loop_on,
		output loop_tx,
		output filt_on,
		input  rx_int,
		input  bus_idle,
		input  wake_evt
	);

endinterface : cmc_det_if

// ### hdl/cmc_idle_det.sv
// Receive-line synchroniser, wake glitch filter, bus-idle counter and wake detector.
// Assumes a bit-time sample tick from the bit-timing logic on the same clock.
`include "cmc_consts.svh"

module cmc_idle_det
	import cmc_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_srst,
	input  wire logic i_bus_rx,
	input  wire logic i_bit_tick,
	cmc_det_if.det    bus
);

	localparam logic [4:0] FILT_LAST = 5'(`CMC_FILT_CYC - 1);

	logic       rx_meta_ff;
	logic       rx_sync_ff;
	logic       rx_filt_ff;
	logic       rx_prev_ff;
	logic [4:0] filt_cnt_ff;
	logic [3:0] idle_cnt_ff;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
		end else if (bus.ce) begin
			rx_meta_ff <= i_bus_rx;
			rx_sync_ff <= rx_meta_ff;
		end
	end

	// Short dominant spikes must not wake a sleeping node, so a change is only taken
	// once it has held for the full filter time.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rx_filt_ff  <= 1'b1;
			filt_cnt_ff <= 5'h0;
		end else if (bus.ce) begin
			if (!bus.filt_on) begin
				rx_filt_ff  <= rx_sync_ff;
				filt_cnt_ff <= 5'h0;
			end else if (rx_sync_ff == rx_filt_ff) begin
				filt_cnt_ff <= 5'h0;
			end else if (filt_cnt_ff == FILT_LAST) begin
				rx_filt_ff  <= rx_sync_ff;
				filt_cnt_ff <= 5'h0;
			end else begin
				filt_cnt_ff <= filt_cnt_ff + 5'h1;
			end
		end
	end

	assign bus.rx_int = bus.loop_on ? bus.loop_tx : rx_filt_ff;

	// A dominant level restarts the count at once, so idle drops in the next cycle.
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			idle_cnt_ff <= 4'h0;
		end else if (bus.ce) begin
			if (!bus.rx_int) begin
				idle_cnt_ff <= 4'h0;
			end else if (i_bit_tick && idle_cnt_ff != `CMC_IDLE_BITS) begin
				idle_cnt_ff <= idle_cnt_ff + 4'h1;
			end
		end
	end

	assign bus.bus_idle = (idle_cnt_ff == `CMC_IDLE_BITS);

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rx_prev_ff <= 1'b1;
		end else if (bus.ce) begin
			rx_prev_ff <= rx_filt_ff;
		end
	end

	assign bus.wake_evt = bus.ce && rx_prev_ff && !rx_filt_ff;

	a_glitch_hold: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		($past(bus.ce) && $past(bus.filt_on) && $changed(rx_filt_ff))
		|-> ($past(filt_cnt_ff) == FILT_LAST))
		else $error("Filtered receive level changed before the filter time.");

	a_idle_needs_bits: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(bus.ce && !bus.rx_int) |=> !bus.bus_idle)
		else $error("Bus reported idle right after a dominant level.");

endmodule : cmc_idle_det

// ### hdl/cmc_mode_ctrl.sv
// Operating-mode controller of a CAN module: request/grant, pin ownership, wake logic.
// Assumes a protocol engine and bit-timing logic on I_CLK_SYS; the pin arrives raw.
`include "cmc_consts.svh"

module cmc_mode_ctrl
	import cmc_pkg::*;
(
	input  wire logic                     I_CLK_SYS,
	input  wire logic                     I_SRST,
	input  wire logic                     I_CE,
	input  wire logic [2:0]               I_MODE_REQ,
	input  wire logic [1:0]               I_RX_MODE,
	input  wire logic                     I_WAKE_IE,
	input  wire logic                     I_WAKE_FILT_EN,
	input  wire logic                     I_WAKE_CLR,
	input  wire logic                     I_CPU_SLEEP,
	input  wire logic                     I_CFG_WR_REQ,
	input  wire logic                     I_BUS_RX,
	input  wire logic                     I_BIT_TICK,
	input  wire logic                     I_PE_TX,
	input  wire logic                     I_PE_TX_BUSY,
	input  wire logic                     I_PE_ERR,
	input  wire logic                     I_PE_SAMPLE,
	input  wire logic [`CMC_PSM_W-1:0]    I_PE_STATE,
	input  wire logic [`CMC_BITCNT_W-1:0] I_PE_BITCNT,
	output logic      [2:0]               O_MODE_STAT,
	output logic                          O_TX_PIN,
	output logic                          O_TX_OE,
	output logic                          O_RX_PIN_OWN,
	output logic                          O_PE_RX,
	output logic                          O_PE_TX_EN,
	output logic                          O_PE_RX_EN,
	output logic                          O_ERR_SIG_EN,
	output logic                          O_LOOP_ACK,
	output logic                          O_ERRCNT_CLR,
	output logic                          O_ERRCNT_RUN,
	output logic                          O_MOD_CLK_EN,
	output logic                          O_INT_EN_OTHERS,
	output logic                          O_CFG_WR_EN,
	output logic                          O_WAKE_FLAG,
	output logic                          O_WAKE_IRQ,
	output logic                          O_ACCEPT_ALL,
	output logic                          O_MAB_COPY,
	output logic                          O_ERR_SAMPLE,
	output logic      [`CMC_PSM_W-1:0]    O_ERR_STATE,
	output logic      [`CMC_BITCNT_W-1:0] O_ERR_BITCNT
);

	// Any code with the top bit set asks for configuration mode.
	function automatic cmc_mode_t norm_mode(input logic [2:0] req);
		norm_mode = req[`CMC_CFG_BIT] ? `CMC_MODE_CONFIG : req;
	endfunction : norm_mode

	function automatic logic is_online(input cmc_mode_t m);
		is_online = (m == `CMC_MODE_NORMAL) || (m == `CMC_MODE_LOOP) ||
			(m == `CMC_MODE_LISTEN);
	endfunction : is_online

	cmc_det_if det_bus ();

	cmc_mode_t  mode_ff;
	cmc_state_t state_ff;
	cmc_mode_t  target;
	cmc_mode_t  nxt_mode;
	logic       grant;
	logic       in_disable;
	logic       in_config;
	logic       running;
	logic       wake_arm;
	logic       tx_oe_ff;
	logic       tx_pin_ff;
	logic       wake_flag_ff;
	logic       mab_copy_ff;
	logic       err_sample_ff;
	logic [`CMC_PSM_W-1:0]    err_state_ff;
	logic [`CMC_BITCNT_W-1:0] err_bitcnt_ff;

	cmc_idle_det u_idle_det (
		.i_clk_sys  (I_CLK_SYS),
		.i_srst     (I_SRST),
		.i_bus_rx   (I_BUS_RX),
		.i_bit_tick (I_BIT_TICK),
		.bus        (det_bus.det)
	);

	assign target     = norm_mode(I_MODE_REQ);
	assign in_disable = (mode_ff == `CMC_MODE_DISABLE);
	assign in_config  = (mode_ff == `CMC_MODE_CONFIG);

	// An online node may only switch at bus idle; configuration mode is left at once, but no other mode is left while its
	// engine still reports a transmission, so configuration is never entered mid-frame.
	assign grant = in_config || (!I_PE_TX_BUSY && (in_disable || det_bus.bus_idle));

	// The pin enable is loaded from the mode about to be granted, so the pin is
	// released in the same cycle in which the status changes.
	assign nxt_mode = (target != mode_ff && state_ff != ST_WAKE_RX && grant) ?
		target : mode_ff;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			mode_ff  <= `CMC_MODE_RESET;
			state_ff <= ST_SETTLED;
		end else if (I_CE) begin
			if (target != mode_ff && state_ff != ST_WAKE_RX) begin
				if (grant) begin
					mode_ff  <= target;
					state_ff <= is_online(target) ? ST_REJOIN : ST_SETTLED;
				end else begin
					state_ff <= ST_PENDING;
				end
			end else begin
				unique case (state_ff)
					ST_SETTLED: begin
						if (in_disable && det_bus.wake_evt && !I_CPU_SLEEP) begin
							state_ff <= ST_WAKE_RX;
						end
					end
					ST_PENDING: begin
						state_ff <= ST_SETTLED;
					end
					ST_REJOIN: begin
						if (det_bus.bus_idle) begin
							state_ff <= ST_SETTLED;
						end
					end
					ST_WAKE_RX: begin
						if (det_bus.bus_idle) begin
							state_ff <= ST_SETTLED;
						end
					end
				endcase
			end
		end
	end

	assign O_MODE_STAT = mode_ff;

	assign det_bus.ce      = I_CE;
	assign det_bus.loop_on = (mode_ff == `CMC_MODE_LOOP);
	assign det_bus.loop_tx = I_PE_TX;
	assign det_bus.filt_on = I_WAKE_FILT_EN && (in_disable || I_CPU_SLEEP);
	assign O_PE_RX         = det_bus.rx_int;

	assign running = is_online(mode_ff) && (state_ff == ST_SETTLED || state_ff == ST_PENDING);

	// A frame seen while the CPU sleeps is dropped: the clocks are too slow to follow it.
	assign O_PE_RX_EN   = !I_CPU_SLEEP && (running || state_ff == ST_WAKE_RX);
	assign O_PE_TX_EN   = running && (mode_ff != `CMC_MODE_LISTEN);
	assign O_ERR_SIG_EN = O_PE_TX_EN;
	assign O_LOOP_ACK   = (mode_ff == `CMC_MODE_LOOP);
	assign O_ERRCNT_CLR = in_config;
	assign O_ERRCNT_RUN = (mode_ff == `CMC_MODE_NORMAL) || (mode_ff == `CMC_MODE_LOOP);
	assign O_MOD_CLK_EN = !in_disable || state_ff == ST_WAKE_RX;
	assign O_INT_EN_OTHERS = !in_disable;
	assign O_CFG_WR_EN  = in_config && I_CFG_WR_REQ;
	assign O_ACCEPT_ALL = (I_RX_MODE == `CMC_RXM_ACCEPT_ALL);
	assign O_RX_PIN_OWN = (mode_ff == `CMC_MODE_NORMAL) || (mode_ff == `CMC_MODE_LISTEN) ||
		in_config;

	// Pin drive is registered so the bus never sees a combinational glitch.
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			tx_oe_ff  <= 1'b0;
			tx_pin_ff <= 1'b1;
		end else if (I_CE) begin
			tx_oe_ff  <= (nxt_mode == `CMC_MODE_NORMAL) ||
				(nxt_mode == `CMC_MODE_CONFIG);
			tx_pin_ff <= (nxt_mode == `CMC_MODE_NORMAL && O_PE_TX_EN) ? I_PE_TX : 1'b1;
		end
	end

	assign O_TX_OE  = tx_oe_ff;
	assign O_TX_PIN = tx_pin_ff;

	// Software keeps the module idle before sleep; the detector is armed either way.
	assign wake_arm = in_disable || I_CPU_SLEEP;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			wake_flag_ff <= 1'b0;
		end else if (I_CE) begin
			if (wake_arm && det_bus.wake_evt) begin
				wake_flag_ff <= 1'b1;
			end else if (I_WAKE_CLR) begin
				wake_flag_ff <= 1'b0;
			end
		end
	end

	assign O_WAKE_FLAG = wake_flag_ff;
	assign O_WAKE_IRQ  = wake_flag_ff && I_WAKE_IE;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			mab_copy_ff   <= 1'b0;
			err_sample_ff <= 1'b0;
			err_state_ff  <= '0;
			err_bitcnt_ff <= '0;
		end else if (I_CE) begin
			mab_copy_ff <= I_PE_ERR && O_ACCEPT_ALL && running;
			if (I_PE_ERR && O_ACCEPT_ALL && running) begin
				err_sample_ff <= I_PE_SAMPLE;
				err_state_ff  <= I_PE_STATE;
				err_bitcnt_ff <= I_PE_BITCNT;
			end
		end
	end

	assign O_MAB_COPY   = mab_copy_ff;
	assign O_ERR_SAMPLE = err_sample_ff;
	assign O_ERR_STATE  = err_state_ff;
	assign O_ERR_BITCNT = err_bitcnt_ff;

	sequence s_err_seen;
		I_CE && I_PE_ERR && O_ACCEPT_ALL && running;
	endsequence

	sequence s_err_stored;
		O_MAB_COPY && (O_ERR_STATE == $past(I_PE_STATE)) &&
			(O_ERR_BITCNT == $past(I_PE_BITCNT));
	endsequence

	a_reset_config: assert property (@(posedge I_CLK_SYS)
		I_SRST |=> (O_MODE_STAT == `CMC_MODE_CONFIG) && O_ERRCNT_CLR && !O_WAKE_FLAG)
		else $error("Reset did not leave configuration mode.");

	a_switch_at_idle: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		($changed(mode_ff) && is_online($past(mode_ff))) |-> $past(det_bus.bus_idle))
		else $error("Mode changed while bus not idle.");

	a_no_cfg_in_tx: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		($past(I_PE_TX_BUSY) && !$past(in_config)) |-> !$rose(in_config))
		else $error("Configuration entered during transmission.");

	a_cfg_write_lock: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		O_CFG_WR_EN |-> (O_MODE_STAT == `CMC_MODE_CONFIG))
		else $error("Configuration write allowed outside configuration mode.");

	a_disable_quiet: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		(in_disable && $past(in_disable)) |-> (!O_TX_OE && !O_PE_TX_EN && !O_INT_EN_OTHERS))
		else $error("Disabled module still drives bus or other interrupts.");

	a_wake_flag_set: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		(I_CE && wake_arm && det_bus.wake_evt) |=> (O_WAKE_FLAG && (O_WAKE_IRQ == I_WAKE_IE)))
		else $error("Wake event did not set the wake flag.");

	a_listen_passive: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		(mode_ff == `CMC_MODE_LISTEN) |-> (!O_ERR_SIG_EN && !O_ERRCNT_RUN && !O_TX_OE))
		else $error("Listen-only mode is not passive.");

	a_rejoin_wait: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		(state_ff == ST_REJOIN) |-> (!O_PE_TX_EN && !O_PE_RX_EN))
		else $error("Traffic allowed before eleven recessive bits.");

	a_err_capture: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		s_err_seen |=> s_err_stored)
		else $error("Error snapshot not captured.");

	a_pending_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		(I_CE && target != mode_ff && !grant && state_ff != ST_WAKE_RX) |=> $stable(mode_ff))
		else $error("Status changed before the switch was granted.");

	a_loop_route: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		(mode_ff == `CMC_MODE_LOOP) |-> (O_PE_RX == I_PE_TX && O_LOOP_ACK && !O_RX_PIN_OWN))
		else $error("Loopback does not route transmit to receive.");

	a_config_quiet: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		in_config |-> (!O_PE_TX_EN && !O_PE_RX_EN && O_ERRCNT_CLR && !O_ERRCNT_RUN))
		else $error("Configuration mode still allows traffic or counting.");

	a_sleep_no_rx: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_CPU_SLEEP |-> !O_PE_RX_EN)
		else $error("Receive enabled while the CPU sleeps.");

	a_ce_freeze: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
		!I_CE |=> ($stable(mode_ff) && $stable(state_ff) && $stable(wake_flag_ff) &&
			$stable(tx_oe_ff)))
		else $error("State moved while the clock enable was low.");

endmodule : cmc_mode_ctrl

// ### verif/cmc_bus_node.sv
// Model of the other nodes on the shared bus: bit-time tick and bus level.
// Assumes the bench calls its tasks at falling clock edges.
module cmc_bus_node (
	input  wire logic i_clk,
	output logic      o_bus_rx,
	output logic      o_bit_tick
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam int BIT_CYC = 4;
	int ph = 0;

	initial begin
		o_bus_rx   = 1'b1;
		o_bit_tick = 1'b0;
	end

	always @(negedge i_clk) begin
		ph = (ph + 1) % BIT_CYC;
		o_bit_tick <= (ph == 0);
	end

	// The line returns recessive when every node lets go, since the bus is pulled that way.
	// One released cycle closes each call, so back-to-back calls never drive one step twice.
	task automatic send_bits(input int n, input bit dom);
		o_bus_rx <= !dom;
		repeat (n * BIT_CYC) @(negedge i_clk);
		o_bus_rx <= 1'b1;
		@(negedge i_clk);
	endtask : send_bits

	task automatic glitch(input int c);
		o_bus_rx <= 1'b0;
		repeat (c) @(negedge i_clk);
		o_bus_rx <= 1'b1;
		@(negedge i_clk);
	endtask : glitch

endmodule : cmc_bus_node

// ### verif/cmc_mode_ctrl_test.sv
// Self-checking bench of the mode controller against a small mode model.
// Assumes the constants header is on the include path; bus nodes are modelled.
`include "cmc_consts.svh"

module cmc_mode_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;

	// Eleven idle bits of four cycles, plus margin for synchroniser and grant.
	localparam int IDLE = 56;
	logic clk, srst, ce, wie, wfe, wclr, slp, cfgw, ptx, pbusy, perr, psmp;
	logic [2:0] mreq;
	logic [1:0] rxm;
	logic [7:0] pst, pbc;
	logic [2:0] mst;
	logic txp, txoe, rxown, perx, ptxen, prxen, esig, lack, eclr, erun, mclk;
	logic intoth, cfgen, wflag, wirq, acc, message_assembly_buffer, esmp, brx, tick;
	logic [7:0] est, ebc;
	logic [31:0] seed = 32'h0000_D274;
	logic [31:0] r;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	int exp_mode;
	logic [16:0] exp_snap[$];
	logic [16:0] snap;

	cmc_bus_node i_cmc_bus_node (.i_clk(clk), .o_bus_rx(brx), .o_bit_tick(tick));

	cmc_mode_ctrl i_cmc_mode_ctrl (
		.I_CLK_SYS(clk), .I_SRST(srst), .I_CE(ce), .I_MODE_REQ(mreq), .I_RX_MODE(rxm),
		.I_WAKE_IE(wie), .I_WAKE_FILT_EN(wfe), .I_WAKE_CLR(wclr), .I_CPU_SLEEP(slp),
		.I_CFG_WR_REQ(cfgw), .I_BUS_RX(brx), .I_BIT_TICK(tick), .I_PE_TX(ptx),
		.I_PE_TX_BUSY(pbusy), .I_PE_ERR(perr), .I_PE_SAMPLE(psmp), .I_PE_STATE(pst),
		.I_PE_BITCNT(pbc), .O_MODE_STAT(mst), .O_TX_PIN(txp), .O_TX_OE(txoe),
		.O_RX_PIN_OWN(rxown), .O_PE_RX(perx), .O_PE_TX_EN(ptxen), .O_PE_RX_EN(prxen),
		.O_ERR_SIG_EN(esig), .O_LOOP_ACK(lack), .O_ERRCNT_CLR(eclr), .O_ERRCNT_RUN(erun),
		.O_MOD_CLK_EN(mclk), .O_INT_EN_OTHERS(intoth), .O_CFG_WR_EN(cfgen),
		.O_WAKE_FLAG(wflag), .O_WAKE_IRQ(wirq), .O_ACCEPT_ALL(acc), .O_MAB_COPY(message_assembly_buffer),
		.O_ERR_SAMPLE(esmp), .O_ERR_STATE(est), .O_ERR_BITCNT(ebc)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic chk_bit(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val

	task automatic clr_wake();
		wclr = 1'b1;
		cyc(1);
		wclr = 1'b0;
		cyc(1);
		chk_bit("wake_flag", 1'b0, wflag);
	endtask : clr_wake

	task automatic final_report();
		$display("Compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	// The whole run takes about 810 cycles; the ceiling leaves ample margin.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		srst = 1'b1; ce = 1'b1; mreq = `CMC_MODE_CONFIG; rxm = 2'h0; wie = 1'b0;
		wfe = 1'b0; wclr = 1'b0; slp = 1'b0; cfgw = 1'b0; ptx = 1'b1; pbusy = 1'b0;
		perr = 1'b0; psmp = 1'b0; pst = 8'h00; pbc = 8'h00;
		cyc(3);
		srst = 1'b0;
		exp_mode = `CMC_MODE_RESET;
		chk_val("mode", 8'(exp_mode), 8'(mst));
		chk_bit("tx_oe", 1'b0, txoe);
		chk_bit("tx_pin", 1'b1, txp);
		chk_bit("errcnt_clr", 1'b1, eclr);
		chk_bit("pe_tx_en", 1'b0, ptxen);
		cfgw = 1'b1;
		#1 chk_bit("cfg_wr_en", 1'b1, cfgen);
		$display("Test reset finished");
		mreq = `CMC_MODE_NORMAL;
		exp_mode = `CMC_MODE_NORMAL;
		cyc(1);
		chk_val("mode", 8'(exp_mode), 8'(mst));
		chk_bit("cfg_wr_en", 1'b0, cfgen);
		chk_bit("pe_tx_en", 1'b0, ptxen);
		cyc(IDLE);
		chk_bit("pe_tx_en", 1'b1, ptxen);
		chk_bit("tx_oe", 1'b1, txoe);
		chk_bit("rx_own", 1'b1, rxown);
		ptx = 1'b0;
		cyc(1);
		chk_bit("tx_pin", 1'b0, txp);
		ptx = 1'b1;
		cyc(1);
		chk_bit("tx_pin", 1'b1, txp);
		$display("Test normal finished");
		mreq = `CMC_MODE_LISTEN;
		exp_mode = `CMC_MODE_LISTEN;
		cyc(IDLE);
		chk_val("mode", 8'(exp_mode), 8'(mst));
		chk_bit("pe_tx_en", 1'b0, ptxen);
		chk_bit("err_sig_en", 1'b0, esig);
		chk_bit("tx_oe", 1'b0, txoe);
		chk_bit("errcnt_run", 1'b0, erun);
		mreq = `CMC_MODE_LOOP;
		exp_mode = `CMC_MODE_LOOP;
		cyc(IDLE);
		chk_val("mode", 8'(exp_mode), 8'(mst));
		chk_bit("loop_ack", 1'b1, lack);
		chk_bit("tx_oe", 1'b0, txoe);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			ptx = r[0];
			cyc(1);
			chk_bit("pe_rx", ptx, perx);
		end
		ptx = 1'b1;
		rxm = `CMC_RXM_ACCEPT_ALL;
		#1 chk_bit("accept_all", 1'b1, acc);
		r = rnd();
		pst = r[7:0];
		pbc = r[15:8];
		psmp = r[16];
		exp_snap.push_back(r[16:0]);
		perr = 1'b1;
		cyc(1);
		perr = 1'b0;
		snap = exp_snap.pop_front();
		chk_bit("mab_copy", 1'b1, message_assembly_buffer);
		chk_val("err_state", snap[7:0], est);
		chk_val("err_bitcnt", snap[15:8], ebc);
		chk_bit("err_sample", snap[16], esmp);
		cyc(1);
		chk_bit("mab_copy", 1'b0, message_assembly_buffer);
		rxm = 2'h0;
		$display("Test listen and loopback finished");
		mreq = `CMC_MODE_NORMAL;
		exp_mode = `CMC_MODE_NORMAL;
		cyc(IDLE);
		// Recessive gaps of three bits keep the bus from ever looking idle; the first
		// burst makes the bus busy before the request is raised.
		i_cmc_bus_node.send_bits(2, 1'b1);
		mreq = `CMC_MODE_DISABLE;
		repeat (6) begin
			i_cmc_bus_node.send_bits(2, 1'b1);
			i_cmc_bus_node.send_bits(3, 1'b0);
		end
		chk_val("mode", 8'(exp_mode), 8'(mst));
		exp_mode = `CMC_MODE_DISABLE;
		cyc(IDLE);
		chk_val("mode", 8'(exp_mode), 8'(mst));
		chk_bit("tx_oe", 1'b0, txoe);
		chk_bit("rx_own", 1'b0, rxown);
		chk_bit("int_others", 1'b0, intoth);
		chk_bit("mod_clk_en", 1'b0, mclk);
		chk_bit("errcnt_run", 1'b0, erun);
		$display("Test disable finished");
		wie = 1'b1;
		i_cmc_bus_node.send_bits(2, 1'b1);
		chk_bit("wake_flag", 1'b1, wflag);
		chk_bit("wake_irq", 1'b1, wirq);
		chk_bit("pe_rx_en", 1'b1, prxen);
		chk_bit("mod_clk_en", 1'b1, mclk);
		cyc(IDLE);
		clr_wake();
		wfe = 1'b1;
		i_cmc_bus_node.glitch(5);
		cyc(30);
		chk_bit("wake_flag", 1'b0, wflag);
		i_cmc_bus_node.send_bits(6, 1'b1);
		chk_bit("wake_flag", 1'b1, wflag);
		cyc(IDLE);
		clr_wake();
		wfe = 1'b0;
		wie = 1'b0;
		slp = 1'b1;
		i_cmc_bus_node.send_bits(2, 1'b1);
		chk_bit("wake_flag", 1'b1, wflag);
		chk_bit("wake_irq", 1'b0, wirq);
		chk_bit("pe_rx_en", 1'b0, prxen);
		slp = 1'b0;
		cyc(IDLE);
		clr_wake();
		$display("Test wake finished");
		mreq = `CMC_MODE_NORMAL;
		exp_mode = `CMC_MODE_NORMAL;
		cyc(IDLE);
		pbusy = 1'b1;
		mreq = `CMC_MODE_CONFIG;
		cyc(IDLE);
		chk_val("mode", 8'(exp_mode), 8'(mst));
		pbusy = 1'b0;
		ce = 1'b0;
		cyc(2);
		chk_val("mode", 8'(exp_mode), 8'(mst));
		ce = 1'b1;
		exp_mode = `CMC_MODE_CONFIG;
		cyc(2);
		chk_val("mode", 8'(exp_mode), 8'(mst));
		chk_bit("errcnt_clr", 1'b1, eclr);
		chk_bit("cfg_wr_en", 1'b1, cfgen);
		$display("Test config lock finished");
		mreq = `CMC_MODE_NORMAL;
		cyc(2);
		chk_val("mode", 8'(`CMC_MODE_NORMAL), 8'(mst));
		srst = 1'b1;
		cyc(3);
		srst = 1'b0;
		chk_val("mode", 8'(`CMC_MODE_RESET), 8'(mst));
		chk_bit("tx_oe", 1'b0, txoe);
		chk_bit("errcnt_clr", 1'b1, eclr);
		chk_bit("mab_copy", 1'b0, message_assembly_buffer);
		chk_val("err_state", 8'h00, est);
		$display("Test reset again finished");
		final_report();
	end

endmodule : cmc_mode_ctrl_test
